// >>> core/xbc_ext_bus_ctrl.sv
/*
  External bus controller: runs CPU accesses onto multiplexed or
  demultiplexed address/data pins with per-window timing, chip selects,
  ready handling and hold/acknowledge arbitration.
  Assumes a CPU side on the same clock and pins from outside the domain.
*/
`default_nettype none

module xbc_ext_bus_ctrl
  import xbc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // cpu access port
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [XBC_AW-1:0] req_addr,
  input wire logic [XBC_DW-1:0] req_wdata,
  output logic rsp_valid,
  output logic [XBC_DW-1:0] rsp_rdata,
  // configuration
  input wire xbc_mode_e bus_mode,
  input wire logic [1:0] addr_space,
  input wire xbc_addrsel_s window_addr_select [XBC_WIN_N],
  input wire xbc_buscfg_s window_bus_config [XBC_WIN_N],
  input wire xbc_buscfg_s default_bus_config,
  input wire logic chip_select_timing_bit,
  input wire logic hold_arbitration_enable,
  input wire logic hold_ack_direction_bit,
  // address and data pins
  input wire logic [XBC_DW-1:0] data_addr_port_pin,
  output logic [XBC_DW-1:0] data_addr_port_drv,
  output logic [XBC_DW-1:0] data_addr_port_oe,
  output logic [15:0] address_port,
  output logic address_port_oe,
  output logic [7:0] upper_addr,
  output logic [7:0] upper_addr_oe,
  // strobes
  output logic ale,
  output logic rd_b,
  output logic wr_b,
  output logic [XBC_CS_N-1:0] chip_select_outputs_b,
  output logic strobe_oe,
  input wire logic ready_pin,
  // arbitration pins
  input wire logic hold_b,
  input wire logic hold_acknowledge_b_pin,
  output logic hold_acknowledge_b_drv,
  output logic hold_acknowledge_b_oe,
  output logic bus_request_out_b,
  output logic bus_request_out_b_oe
);

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_DLY = 6'h04,
    ST_CMD = 6'h08,
    ST_TRI = 6'h10,
    ST_HOLD = 6'h20
  } xbc_state_e;

  xbc_state_e state_reg;
  xbc_state_e state_next;
  logic [XBC_CNT_W-1:0] cnt_reg;
  xbc_buscfg_s cur_cfg_reg;
  logic [XBC_CS_N-1:0] cur_cs_reg;
  logic [XBC_AW-1:0] addr_reg;
  logic [XBC_AW-1:0] addr_next;
  logic [XBC_DW-1:0] wdata_reg;
  logic wr_reg;
  logic cs_late_reg;
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] flt_reg;
  logic [XBC_CNT_W-1:0] strobe_len_reg;
  logic [7:0] up_msk;
  logic ext;
  logic is_mux;
  logic is_b8;
  logic rdy_s;
  logic grant_in;
  logic hold_req;
  logic owner;
  logic take;
  logic done;
  logic drive_bus;

  xbc_win_if wif();

  // mode decode
  assign ext = bus_mode != XBC_MODE_SINGLE;
  assign is_mux = bus_mode == XBC_MODE_MUX16 || bus_mode == XBC_MODE_MUX8;
  assign is_b8 = bus_mode == XBC_MODE_MUX8 || bus_mode == XBC_MODE_DEMUX8;

  // address space restriction
  always_comb begin
    unique case (addr_space)
      XBC_SPACE_1M: up_msk = XBC_UPPER_1M;
      XBC_SPACE_256K: up_msk = XBC_UPPER_256K;
      XBC_SPACE_64K: up_msk = XBC_UPPER_64K;
      default: up_msk = XBC_UPPER_16M;
    endcase
  end

  // window lookup
  assign wif.addr = req_addr & {up_msk, 16'hffff};
  assign wif.win_sel = window_addr_select;
  assign wif.win_cfg = window_bus_config;
  assign wif.dflt_cfg = default_bus_config;

  xbc_win_decode u_dec (
    .w(wif.dec)
  );

  // pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s1_reg <= XBC_SYNC_RST;
      s2_reg <= XBC_SYNC_RST;
      s3_reg <= XBC_SYNC_RST;
      flt_reg <= XBC_SYNC_RST;
    end else begin
      s1_reg <= {hold_acknowledge_b_pin, hold_b, ready_pin};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      flt_reg <= (s2_reg & ~(s2_reg ^ s3_reg)) | (flt_reg & (s2_reg ^ s3_reg));
    end
  end

  assign rdy_s = flt_reg[0];
  assign grant_in = !flt_reg[2];

  // arbitration decode
  assign hold_req = hold_arbitration_enable && !hold_ack_direction_bit && !flt_reg[1];
  assign owner = !(hold_arbitration_enable && hold_ack_direction_bit) || grant_in;
  assign req_ready = state_reg == ST_IDLE && owner && !hold_req;
  assign take = req_valid && req_ready;
  assign addr_next = take ? wif.addr : addr_reg;
  assign drive_bus = ext && owner && state_next != ST_HOLD;

  // cycle ends once waits are spent and, if enabled, ready is at its level
  assign done = cnt_reg == '0 && (!cur_cfg_reg.rdy_en || rdy_s == cur_cfg_reg.rdy_pol);

  // bus cycle sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (hold_req) begin
          state_next = ST_HOLD;
        end else if (take && ext) begin
          state_next = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (cnt_reg == '0) begin
          state_next = cur_cfg_reg.rw_dly ? ST_DLY : ST_CMD;
        end
      end
      ST_DLY: state_next = ST_CMD;
      ST_CMD: begin
        if (done) begin
          state_next = (!wr_reg && cur_cfg_reg.tri_ext) ? ST_TRI : ST_IDLE;
        end
      end
      ST_TRI: state_next = ST_IDLE;
      ST_HOLD: begin
        if (!hold_req) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // phase counter
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cnt_reg <= '0;
    end else if (take) begin
      cnt_reg <= XBC_CNT_W'(wif.cfg.ale_long);
    end else if (state_reg == ST_ADDR && cnt_reg == '0) begin
      cnt_reg <= cur_cfg_reg.wait_cyc;
    end else if (cnt_reg != '0 && state_reg != ST_DLY) begin
      // the delay cycle spends none of the strobe waits
      cnt_reg <= cnt_reg - XBC_CNT_W'(1);
    end
  end

  // access capture
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cur_cfg_reg <= '0;
      cur_cs_reg <= '0;
      addr_reg <= '0;
      wdata_reg <= '0;
      wr_reg <= 1'b0;
    end else if (take) begin
      cur_cfg_reg <= wif.cfg;
      cur_cs_reg <= wif.cs_sel & {XBC_CS_N{wif.cfg.cs_en}};
      addr_reg <= wif.addr;
      wdata_reg <= req_wdata;
      wr_reg <= req_write;
    end
  end

  // latch and read/write strobes
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ale <= 1'b0;
      rd_b <= 1'b1;
      wr_b <= 1'b1;
      strobe_oe <= 1'b0;
    end else begin
      ale <= state_next == ST_ADDR;
      rd_b <= !(state_next == ST_CMD && !wr_reg);
      wr_b <= !(state_next == ST_CMD && wr_reg);
      strobe_oe <= drive_bus;
    end
  end

  // chip selects: with the latch rise, or one tick (half a cpu clock) later
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      chip_select_outputs_b <= XBC_CS_OFF;
      cs_late_reg <= 1'b0;
    end else begin
      cs_late_reg <= take && ext && !chip_select_timing_bit;
      if (take && ext) begin
        if (chip_select_timing_bit) begin
          chip_select_outputs_b <= ~(wif.cs_sel & {XBC_CS_N{wif.cfg.cs_en}});
        end
      end else if (cs_late_reg) begin
        chip_select_outputs_b <= ~cur_cs_reg;
      end else if (state_next == ST_IDLE || state_next == ST_HOLD) begin
        chip_select_outputs_b <= XBC_CS_OFF;
      end
    end
  end

  // shared address/data port
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      data_addr_port_drv <= '0;
      data_addr_port_oe <= '0;
    end else if (state_next == ST_ADDR && is_mux) begin
      data_addr_port_drv <= addr_next[15:0];
      data_addr_port_oe <= XBC_LANE_ALL;
    end else if ((state_next == ST_DLY || state_next == ST_CMD) && wr_reg) begin
      data_addr_port_drv <= wdata_reg;
      data_addr_port_oe <= is_b8 ? XBC_LANE_LO : XBC_LANE_ALL;
    end else begin
      data_addr_port_oe <= '0;
    end
  end

  // dedicated and upper address ports
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      address_port <= '0;
      address_port_oe <= 1'b0;
      upper_addr <= '0;
      upper_addr_oe <= '0;
    end else begin
      address_port <= addr_next[15:0];
      address_port_oe <= drive_bus && !is_mux;
      upper_addr <= addr_next[23:16] & up_msk;
      upper_addr_oe <= drive_bus ? up_msk : 8'h00;
    end
  end

  // response to the cpu
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= (take && !ext) || (state_reg == ST_CMD && done);
      if (take && !ext) begin
        rsp_rdata <= '0;
      end else if (state_reg == ST_CMD && done && !wr_reg) begin
        rsp_rdata <= data_addr_port_pin & (is_b8 ? XBC_LANE_LO : XBC_LANE_ALL);
      end
    end
  end

  // arbitration pins
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hold_acknowledge_b_drv <= 1'b1;
      hold_acknowledge_b_oe <= 1'b0;
      bus_request_out_b <= 1'b1;
      bus_request_out_b_oe <= 1'b0;
    end else begin
      hold_acknowledge_b_oe <= hold_arbitration_enable && !hold_ack_direction_bit;
      hold_acknowledge_b_drv <= state_next != ST_HOLD;
      bus_request_out_b_oe <= hold_arbitration_enable;
      if (hold_ack_direction_bit) begin
        bus_request_out_b <= !(req_valid || state_reg != ST_IDLE);
      end else begin
        bus_request_out_b <= !(state_reg == ST_HOLD && req_valid);
      end
    end
  end

  // strobe length helper
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      strobe_len_reg <= '0;
    end else if (state_reg == ST_CMD) begin
      strobe_len_reg <= strobe_len_reg + XBC_CNT_W'(1);
    end else begin
      strobe_len_reg <= '0;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  a_single_no_bus: assert property (
    req_valid && req_ready && bus_mode == XBC_MODE_SINGLE |=> rsp_valid && !ale)
    else $error("single-chip access reached the bus");

  a_demux_addr: assert property (
    ale && $past(bus_mode == XBC_MODE_DEMUX16 || bus_mode == XBC_MODE_DEMUX8)
    |-> address_port_oe && address_port == addr_reg[15:0])
    else $error("demux address not on address port");

  a_byte_lane: assert property (
    !wr_b && $past(is_b8) |-> data_addr_port_oe[15:8] == 8'h00)
    else $error("high byte driven in 8-bit mode");

  a_mux_addr: assert property (
    $rose(ale) && $past(is_mux) |-> data_addr_port_oe == XBC_LANE_ALL && data_addr_port_drv == addr_reg[15:0])
    else $error("mux address phase wrong");

  a_ale_short: assert property (
    $rose(ale) && !cur_cfg_reg.ale_long |=> !ale)
    else $error("short latch strobe too long");

  a_strobe_len: assert property (
    state_reg == ST_CMD && state_next != ST_CMD && !cur_cfg_reg.rdy_en |-> strobe_len_reg == cur_cfg_reg.wait_cyc)
    else $error("strobe length differs from wait count");

  a_win_top: assert property (
    wif.hit[3] |-> wif.cs_sel == 5'h10 && wif.cfg == window_bus_config[3])
    else $error("window four not preferred");

  a_win_two: assert property (
    wif.hit[1] && !wif.hit[2] && !wif.hit[3] |-> wif.cs_sel == 5'h04)
    else $error("window two not preferred over one");

  a_default_cfg: assert property (
    wif.hit == 4'h0 |-> wif.cs_sel == XBC_CS_DFLT && wif.cfg == default_bus_config)
    else $error("default configuration not used");

  a_cs_onehot: assert property (
    $onehot0(~chip_select_outputs_b))
    else $error("more than one chip select active");

  a_ready_wait: assert property (
    state_reg == ST_CMD && cnt_reg == '0 && cur_cfg_reg.rdy_en && rdy_s != cur_cfg_reg.rdy_pol
    |=> state_reg == ST_CMD)
    else $error("cycle ended without ready level");

  a_hold_off: assert property (
    !$past(hold_arbitration_enable) |-> !hold_acknowledge_b_oe && !bus_request_out_b_oe)
    else $error("arbitration pins driven while disabled");

  a_master_ack: assert property (
    $past(hold_arbitration_enable && !hold_ack_direction_bit) |-> hold_acknowledge_b_oe)
    else $error("master acknowledge not driven");

  a_slave_ack: assert property (
    $past(hold_ack_direction_bit) |-> !hold_acknowledge_b_oe)
    else $error("slave acknowledge driven");

  a_upper_lines: assert property (
    strobe_oe |-> upper_addr_oe == $past(up_msk) && (upper_addr & ~upper_addr_oe) == 8'h00)
    else $error("upper address lines wrong for space");

  a_cs_late: assert property (
    $rose(ale) && !$past(chip_select_timing_bit) && cur_cs_reg != '0
    |-> chip_select_outputs_b == XBC_CS_OFF ##1 chip_select_outputs_b == ~cur_cs_reg)
    else $error("chip select not half a clock late");

  a_cs_early: assert property (
    $rose(ale) && $past(chip_select_timing_bit) |-> chip_select_outputs_b == ~cur_cs_reg)
    else $error("chip select not with latch rise");

  a_hold_float: assert property (
    state_reg == ST_HOLD |-> !strobe_oe && data_addr_port_oe == '0 && !hold_acknowledge_b_drv)
    else $error("bus not floated during hold");

endmodule

`default_nettype wire

// >>> inc/xbc_pkg.sv
/*
  Shared constants and types of the external bus controller: bus modes,
  address-space sizes, window address-select and bus-configuration layouts.
  Assumes a single 125 MHz clock in which one tick stands for half a CPU clock.
*/
`default_nettype none

package xbc_pkg;

  localparam int XBC_WIN_N = 4;
  localparam int XBC_CS_N = 5;
  localparam int XBC_AW = 24;
  localparam int XBC_DW = 16;
  localparam int XBC_BASE_W = 12;
  localparam int XBC_CNT_W = 4;

  // chip-select lag in ticks: one tick is half a CPU clock
  localparam int XBC_CS_LAG = 1;

  typedef enum logic [2:0] {
    XBC_MODE_SINGLE = 3'h0,
    XBC_MODE_DEMUX16 = 3'h1,
    XBC_MODE_MUX16 = 3'h2,
    XBC_MODE_MUX8 = 3'h3,
    XBC_MODE_DEMUX8 = 3'h4
  } xbc_mode_e;

  localparam logic [1:0] XBC_SPACE_16M = 2'h0;
  localparam logic [1:0] XBC_SPACE_1M = 2'h1;
  localparam logic [1:0] XBC_SPACE_256K = 2'h2;
  localparam logic [1:0] XBC_SPACE_64K = 2'h3;

  localparam logic [7:0] XBC_UPPER_16M = 8'hff;
  localparam logic [7:0] XBC_UPPER_1M = 8'h0f;
  localparam logic [7:0] XBC_UPPER_256K = 8'h03;
  localparam logic [7:0] XBC_UPPER_64K = 8'h00;

  localparam logic [15:0] XBC_LANE_ALL = 16'hffff;
  localparam logic [15:0] XBC_LANE_LO = 16'h00ff;
  localparam logic [XBC_CS_N-1:0] XBC_CS_OFF = 5'h1f;
  localparam logic [XBC_CS_N-1:0] XBC_CS_DFLT = 5'h01;
  // synchroniser reset: hold idle high, acknowledge idle high, ready low
  localparam logic [2:0] XBC_SYNC_RST = 3'h6;

  typedef struct packed {
    logic cs_en;
    logic rdy_en;
    logic rdy_pol;
    logic ale_long;
    logic rw_dly;
    logic tri_ext;
    logic [XBC_CNT_W-1:0] wait_cyc;
  } xbc_buscfg_s;

  // window covers addr[23:12] == base, ignoring the low size bits
  typedef struct packed {
    logic en;
    logic [XBC_BASE_W-1:0] base;
    logic [3:0] size;
  } xbc_addrsel_s;

endpackage

`default_nettype wire

// >>> inc/xbc_win_if.sv
/*
  Window lookup carrier between the bus controller and its window decoder.
  Assumes the controller drives address and tables, the decoder answers.
*/
`default_nettype none

interface xbc_win_if;
  import xbc_pkg::*;
  logic [XBC_AW-1:0] addr;
  xbc_addrsel_s win_sel [XBC_WIN_N];
  xbc_buscfg_s win_cfg [XBC_WIN_N];
  xbc_buscfg_s dflt_cfg;
  logic [XBC_WIN_N-1:0] hit;
  logic [XBC_CS_N-1:0] cs_sel;
  xbc_buscfg_s cfg;
  modport ctrl (output addr, win_sel, win_cfg, dflt_cfg, input hit, cs_sel, cfg);
  modport dec (input addr, win_sel, win_cfg, dflt_cfg, output hit, cs_sel, cfg);
endinterface

`default_nettype wire

// >>> core/xbc_win_decode.sv
/*
  Address window decoder: matches an address against four windows and picks
  the bus configuration and chip select. Assumes a purely combinational use.
*/
`default_nettype none

module xbc_win_decode
  import xbc_pkg::*;
(
  // lookup
  xbc_win_if.dec w
);

  logic [XBC_BASE_W-1:0] msk [XBC_WIN_N];

  genvar g;
  generate
    for (g = 0; g < XBC_WIN_N; g++) begin : g_win
      assign msk[g] = ~((XBC_BASE_W'(1) << w.win_sel[g].size) - XBC_BASE_W'(1));
      assign w.hit[g] = w.win_sel[g].en &&
        ((w.addr[XBC_AW-1 -: XBC_BASE_W] & msk[g]) == (w.win_sel[g].base & msk[g]));
    end
  endgenerate

  // later windows overwrite earlier ones, so the highest window wins
  always_comb begin
    w.cs_sel = XBC_CS_DFLT;
    w.cfg = w.dflt_cfg;
    for (int i = 0; i < XBC_WIN_N; i++) begin
      if (w.hit[i]) begin
        w.cs_sel = XBC_CS_N'(XBC_CS_DFLT << (i + 1));
        w.cfg = w.win_cfg[i];
      end
    end
  end

endmodule

`default_nettype wire

// >>> test/xbc_ext_mem.sv
/*
  External memory and ready source facing the bus controller pins.
  Assumes the bench resolves the shared data wire from the controller's lane enables alone.
*/
`default_nettype none

module xbc_ext_mem (
  // clock
  input wire logic clock,
  // bus pins
  input wire logic ale,
  input wire logic rd_b,
  input wire logic wr_b,
  input wire logic mux,
  input wire logic [15:0] dbus,
  input wire logic [15:0] address_port,
  output logic [15:0] mem_q,
  // ready control
  input wire logic rdy_pol,
  input wire logic [3:0] rdy_dly,
  output logic ready_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [256];
  logic [7:0] adr_reg;
  logic [15:0] flt_reg = 16'h5a5a;
  logic [3:0] cnt_reg = 4'h0;
  // address off the shared or the address port
  always @(posedge clock) begin
    if (ale) begin
      adr_reg <= mux ? dbus[7:0] : address_port[7:0];
    end
    if (!wr_b) begin
      mem[adr_reg] <= dbus;
    end
    flt_reg <= ~flt_reg;
    cnt_reg <= (rd_b && wr_b) ? 4'h0 : cnt_reg + {3'h0, cnt_reg != 4'hf};
  end
  // released wire changes every cycle
  assign mem_q = !rd_b ? mem[adr_reg] : flt_reg;
  // ready active after rdy_dly strobe cycles
  assign ready_pin = (cnt_reg >= rdy_dly) ? rdy_pol : ~rdy_pol;
endmodule

`default_nettype wire

// >>> test/testbench.sv
/*
  Self-checking bench of the bus controller: modes, windows, timing,
  ready, address space and arbitration through CPU accesses.
  Assumes the controller ports as declared and a 125 MHz clock.
*/
`default_nettype none

module testbench;
  import xbc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic rq = 1'b0;
  logic rw = 1'b0;
  logic [23:0] ra = '0;
  logic [15:0] rwd = '0;
  xbc_mode_e bus_mode = XBC_MODE_SINGLE;
  logic [1:0] spc = 2'h0;
  xbc_addrsel_s wsel [XBC_WIN_N];
  xbc_buscfg_s wcfg [XBC_WIN_N];
  xbc_buscfg_s dcfg = '0;
  logic cs_tim = 1'b0;
  logic hold_en = 1'b0;
  logic hdir = 1'b0;
  logic hold_b = 1'b1;
  logic hack_in = 1'b1;
  logic rpol = 1'b0;
  logic [3:0] rdly = 4'h0;
  logic rr, rv, aoe, ale, rd_b, wr_b, soe, rdy, hdrv, hoe, hpin, bus_request_out, bus_request_out_oe, mux;
  logic [15:0] rdat, dpin, ddrv, doe, aport, mq, ap_v, dp_v, rd_v, lm;
  logic [7:0] up, upoe, up_v, upoe_v;
  logic [4:0] csb, cs_v;
  logic ap_oe_v;
  int num_errors = 0;
  int num_checks = 0;
  int ale_k, cs_k, lat, i, n;

  assign mux = bus_mode == XBC_MODE_MUX16 || bus_mode == XBC_MODE_MUX8;
  assign dpin = (doe & ddrv) | (~doe & mq);
  assign hpin = hoe ? hdrv : hack_in;

  xbc_ext_bus_ctrl xbc_ext_bus_ctrl_i (.clock(clock), .rst_b(rst_b), .req_valid(rq), .req_ready(rr),
    .req_write(rw), .req_addr(ra), .req_wdata(rwd), .rsp_valid(rv), .rsp_rdata(rdat), .bus_mode(bus_mode),
    .addr_space(spc), .window_addr_select(wsel), .window_bus_config(wcfg), .default_bus_config(dcfg),
    .chip_select_timing_bit(cs_tim), .hold_arbitration_enable(hold_en), .hold_ack_direction_bit(hdir),
    .data_addr_port_pin(dpin), .data_addr_port_drv(ddrv), .data_addr_port_oe(doe), .address_port(aport),
    .address_port_oe(aoe), .upper_addr(up), .upper_addr_oe(upoe), .ale(ale), .rd_b(rd_b), .wr_b(wr_b),
    .chip_select_outputs_b(csb), .strobe_oe(soe), .ready_pin(rdy), .hold_b(hold_b),
    .hold_acknowledge_b_pin(hpin), .hold_acknowledge_b_drv(hdrv), .hold_acknowledge_b_oe(hoe),
    .bus_request_out_b(bus_request_out), .bus_request_out_b_oe(bus_request_out_oe));

  xbc_ext_mem xbc_ext_mem_i (.clock(clock), .ale(ale), .rd_b(rd_b), .wr_b(wr_b), .mux(mux), .dbus(dpin),
    .address_port(aport), .mem_q(mq), .rdy_pol(rpol), .rdy_dly(rdly), .ready_pin(rdy));

  initial begin
    forever #4 clock = ~clock;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one access; records latch, chip-select and completion cycles
  task automatic acc(input logic w, input logic [23:0] a, input logic [15:0] d);
    int k;
    @(posedge clock);
    rq <= 1'b1;
    rw <= w;
    ra <= a;
    rwd <= d;
    ale_k = -1;
    cs_k = -1;
    lat = -1;
    cs_v = XBC_CS_OFF;
    #1;
    for (k = 0; rr !== 1'b1; k++) begin
      if (k > 60) begin
        num_errors++;
        end_of_test();
      end
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    rq <= 1'b0;
    for (k = 0; lat < 0; k++) begin
      #1;
      if (ale === 1'b1 && ale_k < 0) begin
        ale_k = k;
        ap_v = aport;
        ap_oe_v = aoe;
        dp_v = ddrv;
        up_v = up;
        upoe_v = upoe;
      end
      if (csb !== XBC_CS_OFF && cs_k < 0) begin
        cs_k = k;
        cs_v = csb;
      end
      if (rv === 1'b1) begin
        lat = k;
        rd_v = rdat;
      end else if (k > 60) begin
        num_errors++;
        end_of_test();
      end else begin
        @(posedge clock);
      end
    end
  endtask

  task automatic wait_ack(input logic lvl);
    for (n = 0; n < 12 && hdrv !== lvl; n++) begin
      @(posedge clock);
      #1;
    end
    if (hdrv !== lvl) begin
      num_errors++;
      end_of_test();
    end
  endtask

  xbc_mode_e md [4] = '{XBC_MODE_DEMUX16, XBC_MODE_MUX16, XBC_MODE_MUX8, XBC_MODE_DEMUX8};
  logic [11:0] bs [4] = '{12'h010, 12'h012, 12'h020, 12'h021};
  logic [3:0] sz [4] = '{4'h4, 4'h0, 4'h4, 4'h0};
  logic [23:0] ad [5] = '{24'h011020, 24'h012040, 24'h020080, 24'h021060, 24'h000100};
  logic [4:0] ce [5] = '{5'h1d, 5'h1b, 5'h17, 5'h0f, 5'h1e};
  logic [7:0] eu [4] = '{8'hab, 8'h0b, 8'h03, 8'h00};
  logic [7:0] eo [4] = '{XBC_UPPER_16M, XBC_UPPER_1M, XBC_UPPER_256K, XBC_UPPER_64K};

  initial begin
    for (i = 0; i < XBC_WIN_N; i++) begin
      wsel[i] = '0;
      wcfg[i] = '0;
    end
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    chk(hdrv, 1'b1);
    chk(csb, XBC_CS_OFF);
    acc(1'b0, 24'h000100, 16'h0);
    chk(rd_v, 16'h0);
    chk(ale_k, -1);
    for (i = 0; i < 4; i++) begin
      @(posedge clock);
      bus_mode <= md[i];
      acc(1'b1, 24'h000040 + i, 16'hc3a5 ^ i);
      acc(1'b0, 24'h000040 + i, 16'h0);
      lm = (i >= 2) ? XBC_LANE_LO : XBC_LANE_ALL;
      chk(rd_v & lm, (16'hc3a5 ^ i) & lm);
      chk(mux ? dp_v : ap_v, 16'h0040 + i);
      chk(ap_oe_v, !mux);
      chk(lat, 2);
    end
    @(posedge clock);
    bus_mode <= XBC_MODE_DEMUX16;
    dcfg <= '{cs_en: 1'b1, default: '0};
    for (i = 0; i < XBC_WIN_N; i++) begin
      wsel[i] <= '{en: 1'b1, base: bs[i], size: sz[i]};
      wcfg[i] <= '{cs_en: 1'b1, wait_cyc: 4'(i + 1), default: '0};
    end
    for (i = 0; i < 5; i++) begin
      acc(1'b1, ad[i], 16'h1234 + i);
      chk(cs_v, ce[i]);
      chk(lat, (i + 1) % 5 + 2);
      chk(cs_k - ale_k, 1);
    end
    @(posedge clock);
    cs_tim <= 1'b1;
    acc(1'b0, ad[0], 16'h0);
    chk(cs_k - ale_k, 0);
    chk(rd_v, 16'h1234);
    @(posedge clock);
    cs_tim <= 1'b0;
    dcfg <= '{cs_en: 1'b1, ale_long: 1'b1, rw_dly: 1'b1, tri_ext: 1'b1, wait_cyc: 4'h5, default: '0};
    acc(1'b0, ad[4], 16'h0);
    chk(lat, 9);
    chk(rr, 1'b0);
    chk(rd_v, 16'h1238);
    for (i = 0; i < 2; i++) begin
      @(posedge clock);
      dcfg <= '{cs_en: 1'b1, rdy_en: 1'b1, rdy_pol: i[0], default: '0};
      rpol <= i[0];
      rdly <= 4'h6;
      // let the synchronised ready level settle first
      repeat (5) @(posedge clock);
      acc(1'b0, ad[4], 16'h0);
      chk(lat >= 8 && lat < 20, 1'b1);
      chk(rd_v, 16'h1238);
    end
    @(posedge clock);
    dcfg <= '{cs_en: 1'b1, default: '0};
    for (i = 0; i < 4; i++) begin
      @(posedge clock);
      spc <= i[1:0];
      acc(1'b1, 24'habcdef, 16'h0);
      chk(up_v, eu[i]);
      chk(upoe_v, eo[i]);
    end
    @(posedge clock);
    spc <= 2'h0;
    hold_en <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    chk(hoe, 1'b1);
    chk(bus_request_out_oe, 1'b1);
    @(posedge clock);
    hold_b <= 1'b0;
    wait_ack(1'b0);
    chk(hdrv, 1'b0);
    chk({soe, doe, rr}, 18'h0);
    @(posedge clock);
    rw <= 1'b0;
    ra <= ad[4];
    rq <= 1'b1;
    @(posedge clock);
    #1;
    chk(bus_request_out, 1'b0);
    @(posedge clock);
    hold_b <= 1'b1;
    wait_ack(1'b1);
    chk(hdrv, 1'b1);
    acc(1'b0, ad[4], 16'h0);
    chk(rd_v, 16'h1238);
    @(posedge clock);
    hdir <= 1'b1;
    rq <= 1'b1;
    rw <= 1'b0;
    ra <= ad[4];
    repeat (8) @(posedge clock);
    #1;
    chk(hoe, 1'b0);
    chk({rr, bus_request_out}, 2'h0);
    @(posedge clock);
    hack_in <= 1'b0;
    acc(1'b0, ad[4], 16'h0);
    chk(rd_v, 16'h1238);
    end_of_test();
  end
endmodule

`default_nettype wire
